// *** verilog/speech_host_port.sv ***
// host parallel port: ready handshake, busy timing and bus release
`timescale 1ns/1ps
module speech_host_port
  import speech_port_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // host pins
  input wire logic write_select_n_i,
  input wire logic read_select_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_o,
  // clock source pins
  input wire logic clk_src_strap_i,
  input wire logic oscillator_input_i,
  output logic mem_clk_tick_o,
  // core side
  input wire logic [7:0] status_i,
  input wire logic [7:0] read_data_i,
  output logic [7:0] cmd_o,
  output logic cmd_valid_o,
  output logic power_clear_o
);
  // two-stage synchronisers for all pins
  logic [11:0] s1_r, s2_r;
  host_bus_t bus;
  logic strap_s, osc_s;
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s1_r <= 12'h0FF0 | 12'hC00;
      s2_r <= 12'h0FF0 | 12'hC00;
    end else begin
      s1_r <= {write_select_n_i, read_select_n_i, data_i, clk_src_strap_i, oscillator_input_i};
      s2_r <= s1_r;
    end
  end
  assign bus = host_bus_t'(s2_r[11:2]);
  assign strap_s = s2_r[1];
  assign osc_s = s2_r[0];
  logic sys_tick;
  sys_clock_gen u_clk (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .clk_src_strap_i(strap_s),
    .oscillator_input_i(osc_s),
    .sys_tick_o(sys_tick),
    .mem_tick_o(mem_clk_tick_o)
  );
  port_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt; // ready phase timer in system ticks
  logic [15:0] busy_r, busy_nxt; // command busy timer in system ticks
  logic [15:0] rel_r, rel_nxt; // bus release timer in mclk cycles
  logic la_prev_r, la_prev_nxt; // previous command was load address
  logic rd_byte_r, rd_byte_nxt; // byte read pending from last command
  logic rdy_r, rdy_nxt, oe_r, oe_nxt, cv_r, cv_nxt;
  logic [7:0] dout_r, dout_nxt, cmd_r, cmd_nxt;
  logic [2:0] op;
  assign op = bus.data[6:4];
  // main handshake state machine
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (sys_tick && cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
    busy_nxt = (sys_tick && busy_r != 16'h0000) ? busy_r - 16'h0001 : busy_r;
    rel_nxt = (rel_r != 16'h0000) ? rel_r - 16'h0001 : rel_r;
    la_prev_nxt = la_prev_r;
    rd_byte_nxt = rd_byte_r;
    rdy_nxt = rdy_r;
    oe_nxt = oe_r;
    cv_nxt = 1'b0;
    dout_nxt = dout_r;
    cmd_nxt = cmd_r;
    if (oe_r && rel_r == 16'h0001) begin
      oe_nxt = 1'b0;
    end
    case (st_r)
      ST_IDLE: begin
        if (!bus.write_select_n && !bus.read_select_n) begin
          st_nxt = ST_CLEAR;
        end else if (!bus.write_select_n) begin
          rdy_nxt = 1'b1;
          cnt_nxt = RDY_TICKS;
          st_nxt = ST_WR_RDY;
        end else if (!bus.read_select_n) begin
          rdy_nxt = 1'b1;
          oe_nxt = 1'b1;
          rel_nxt = 16'h0000;
          if (rd_byte_r) begin
            cnt_nxt = la_prev_r ? FETCH_LA_TICKS : FETCH_TICKS;
          end else begin
            cnt_nxt = STAT_TICKS;
          end
          st_nxt = ST_RD_RDY;
        end
      end
      ST_WR_RDY: begin
        // early command: ready stays up until the busy count expires
        if (cnt_r == 16'h0000 && busy_r == 16'h0000) begin
          rdy_nxt = 1'b0;
          cmd_nxt = bus.data;
          cv_nxt = 1'b1;
          rd_byte_nxt = (op == OP_READ_BYTE);
          la_prev_nxt = (op == OP_LOAD_ADDR);
          case (op)
            OP_READ_BRANCH: busy_nxt = us_to_ticks(BUSY_RB_US);
            OP_LOAD_ADDR: busy_nxt = us_to_ticks(BUSY_LA_US);
            OP_SPEAK: busy_nxt = la_prev_r ? us_to_ticks(BUSY_SPK_LA_US)
                                           : us_to_ticks(BUSY_SPK_US);
            OP_SPEAK_EXT: busy_nxt = us_to_ticks(BUSY_SPX_US);
            OP_RESET: busy_nxt = us_to_ticks(BUSY_RST_US);
            default: busy_nxt = 16'h0000;
          endcase
          st_nxt = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        if (bus.write_select_n) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RD_RDY: begin
        if (cnt_r == 16'h0000) begin
          dout_nxt = rd_byte_r ? read_data_i : status_i;
          rdy_nxt = 1'b0;
          rd_byte_nxt = 1'b0;
          busy_nxt = us_to_ticks(BUSY_RD_US);
          st_nxt = ST_RD_DONE;
        end
      end
      ST_RD_DONE: begin
        if (bus.read_select_n) begin
          rel_nxt = REL_CYC;
          st_nxt = ST_IDLE;
        end
      end
      ST_CLEAR: begin
        rdy_nxt = 1'b0;
        oe_nxt = 1'b0;
        busy_nxt = 16'h0000;
        la_prev_nxt = 1'b0;
        rd_byte_nxt = 1'b0;
        if (bus.write_select_n || bus.read_select_n) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end
  // registers only
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      busy_r <= 16'h0000;
      rel_r <= 16'h0000;
      la_prev_r <= 1'b0;
      rd_byte_r <= 1'b0;
      rdy_r <= 1'b0;
      oe_r <= 1'b0;
      cv_r <= 1'b0;
      dout_r <= 8'h00;
      cmd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      rel_r <= rel_nxt;
      la_prev_r <= la_prev_nxt;
      rd_byte_r <= rd_byte_nxt;
      rdy_r <= rdy_nxt;
      oe_r <= oe_nxt;
      cv_r <= cv_nxt;
      dout_r <= dout_nxt;
      cmd_r <= cmd_nxt;
    end
  end
  assign ready_o = rdy_r;
  assign data_o = dout_r;
  assign data_oe_o = oe_r;
  assign cmd_o = cmd_r;
  assign cmd_valid_o = cv_r;
  assign power_clear_o = (st_r == ST_CLEAR);
  // assertion helpers: cycles that ready has stood high, and cycles that the
  // data bus has stayed driven after read-select went high; both saturate
  logic [15:0] rdy_age_r, rdy_age_nxt;
  logic [15:0] oe_age_r, oe_age_nxt;
  always_comb begin
    rdy_age_nxt = 16'h0000;
    oe_age_nxt = 16'h0000;
    if (rdy_r) begin
      rdy_age_nxt = (rdy_age_r == 16'hFFFF) ? rdy_age_r : rdy_age_r + 16'h0001;
    end
    if (oe_r && st_r != ST_RD_RDY && st_r != ST_RD_DONE) begin
      oe_age_nxt = (oe_age_r == 16'hFFFF) ? oe_age_r : oe_age_r + 16'h0001;
    end
  end
  // registers only
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdy_age_r <= 16'h0000;
      oe_age_r <= 16'h0000;
    end else begin
      rdy_age_r <= rdy_age_nxt;
      oe_age_r <= oe_age_nxt;
    end
  end
  // ready pulse never shorter than the 18 us minimum, counted in mclk cycles, after a write
  property p_rdy_min;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r == ST_WR_HOLD && $fell(rdy_r)) |-> (rdy_age_r >= RDY_MIN_NS / MCLK_NS);
  endproperty
  a_rdy_min: assert property (p_rdy_min) else $error("ready dropped early");
  property p_busy_hold;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r == ST_WR_RDY && busy_r != 16'h0000) |=> rdy_r;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("ready fell while busy");
  property p_clear;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r == ST_IDLE && !bus.write_select_n && !bus.read_select_n) |=> power_clear_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not entered");
  property p_release;
    @(posedge mclk_i) disable iff (!resetn_i)
    oe_age_r <= REL_CYC;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_rd_data;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r == ST_RD_RDY && cnt_r == 16'h0000) |=> (oe_r && !rdy_r);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read not completed");
  property p_cmd;
    @(posedge mclk_i) disable iff (!resetn_i)
    cv_r |-> (st_r == ST_WR_HOLD && !rdy_r);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command latched off cycle");
  property p_read_start;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r == ST_IDLE && bus.write_select_n && !bus.read_select_n) |=> (rdy_r && oe_r);
  endproperty
  a_read_start: assert property (p_read_start) else $error("read ready missing");
  property p_byte_timer;
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r == ST_IDLE && !bus.read_select_n && bus.write_select_n && rd_byte_r)
      |=> (cnt_r == FETCH_TICKS || cnt_r == FETCH_LA_TICKS);
  endproperty
  a_byte_timer: assert property (p_byte_timer) else $error("byte read timer wrong");
  c_write: cover property (@(posedge mclk_i) disable iff (!resetn_i) cv_r);
  c_read: cover property (@(posedge mclk_i) disable iff (!resetn_i) st_r == ST_RD_DONE);
  c_clear: cover property (@(posedge mclk_i) disable iff (!resetn_i) power_clear_o);
endmodule

// *** include/speech_port_pkg.sv ***
// constants and types for the speech processor host port timing block
// Behaviour
// - ready high 18 to 26 us after write
// - early command holds ready until done
// - status data stable 6 to 11 us
// - release data bus within 10.5 us
// - byte read ready within 320/440 us
// - system clock runs at 640 kHz
// - memory clock is system clock over four
// - strap low selects external 320 kHz clock
// - strap open or high selects internal oscillator
// - ready drops when data stable or latched
// - both selects low starts power-up clear
package speech_port_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SYS_HZ = 640_000;
  localparam int unsigned EXT_HZ = 320_000;
  localparam int unsigned MEM_DIV = 4;
  // phase increment of a 32-bit accumulator making the system-clock enable
  localparam logic [31:0] SYS_INC = 32'(64'(SYS_HZ) * 64'h1_0000_0000 / 64'(CLK_HZ));
  // ready high pulse, expressed in ns and as system-clock ticks (1562.5 ns each)
  localparam int unsigned RDY_MIN_NS = 18_000;
  localparam int unsigned RDY_MAX_NS = 26_000;
  localparam int unsigned TICK_PS = 1_562_500;
  localparam logic [15:0] RDY_TICKS = 16'((RDY_MIN_NS * 1000 + TICK_PS - 1) / TICK_PS + 1);
  // status data valid 6..11 us after ready high; byte read data after fetch
  localparam int unsigned STAT_NS = 8_000;
  localparam logic [15:0] STAT_TICKS = 16'(STAT_NS * 1000 / TICK_PS);
  localparam int unsigned FETCH_NS = 300_000;
  localparam int unsigned FETCH_LA_NS = 420_000;
  localparam logic [15:0] FETCH_TICKS = 16'(FETCH_NS * 1000 / TICK_PS);
  localparam logic [15:0] FETCH_LA_TICKS = 16'(FETCH_LA_NS * 1000 / TICK_PS);
  // busy periods of each command except read byte, and of a read, in microseconds
  localparam int unsigned BUSY_RB_US = 595;
  localparam int unsigned BUSY_LA_US = 42;
  localparam int unsigned BUSY_SPK_LA_US = 287;
  localparam int unsigned BUSY_SPK_US = 56;
  localparam int unsigned BUSY_SPX_US = 42;
  localparam int unsigned BUSY_RST_US = 300;
  localparam int unsigned BUSY_RD_US = 12;
  // bus release after read-select high, in mclk cycles (10.5 us max); the pin
  // synchroniser and the state register use PIN_LAT_CYC of that budget first
  localparam int unsigned REL_NS = 10_500;
  localparam int unsigned MCLK_NS = 4;
  localparam int unsigned PIN_LAT_CYC = 3;
  localparam logic [15:0] REL_CYC = 16'(REL_NS / MCLK_NS - PIN_LAT_CYC);
  // command decode on bits 6..4
  localparam logic [2:0] OP_LOAD_ADDR = 3'h4;
  localparam logic [2:0] OP_SPEAK = 3'h5;
  localparam logic [2:0] OP_SPEAK_EXT = 3'h6;
  localparam logic [2:0] OP_READ_BYTE = 3'h1;
  localparam logic [2:0] OP_READ_BRANCH = 3'h3;
  localparam logic [2:0] OP_RESET = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_RDY = 3'b001,
    ST_WR_HOLD = 3'b010,
    ST_RD_RDY = 3'b011,
    ST_RD_DONE = 3'b100,
    ST_CLEAR = 3'b101
  } port_state_t;
  typedef struct packed {
    logic write_select_n;
    logic read_select_n;
    logic [7:0] data;
  } host_bus_t;
  function automatic logic [15:0] us_to_ticks(input int unsigned us);
    us_to_ticks = 16'((us * 1_000_000 + TICK_PS - 1) / TICK_PS);
  endfunction
endpackage

// *** verilog/sys_clock_gen.sv ***
// system and memory clock enables from internal oscillator or external clock
`timescale 1ns/1ps
module sys_clock_gen
  import speech_port_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // clock source
  input wire logic clk_src_strap_i, // synchronised strap level
  input wire logic oscillator_input_i, // synchronised external clock
  // enables
  output logic sys_tick_o,
  output logic mem_tick_o
);
  logic [31:0] acc_r, acc_nxt; // internal oscillator phase
  logic ext_prev_r, ext_prev_nxt; // last external level
  logic [1:0] div_r, div_nxt; // memory clock divider
  logic tick;
  // strap low runs the block from both edges of the external 320 kHz square wave,
  // giving 640 kHz; otherwise the internal phase accumulator does
  always_comb begin
    {ext_prev_nxt, acc_nxt} = {oscillator_input_i, acc_r + SYS_INC};
    if (!clk_src_strap_i) begin
      tick = oscillator_input_i ^ ext_prev_r;
    end else begin
      tick = acc_nxt < acc_r;
    end
    div_nxt = tick ? div_r + 2'h1 : div_r;
  end
  // registers only
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      acc_r <= 32'h0000_0000;
      ext_prev_r <= 1'b0;
      div_r <= 2'h0;
    end else begin
      acc_r <= acc_nxt;
      ext_prev_r <= ext_prev_nxt;
      div_r <= div_nxt;
    end
  end
  assign sys_tick_o = tick;
  assign mem_tick_o = tick && (div_r == 2'(MEM_DIV - 1));
endmodule

// *** tb/host_cpu_model.sv ***
// host cpu model that drives the speech port strobes and data bus
`timescale 1ns/1ps
module host_cpu_model
  import speech_port_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // device side
  input wire logic ready_i,
  input wire logic [7:0] bus_i,
  // host strobes and data
  output logic write_select_n_o,
  output logic read_select_n_o,
  output logic [7:0] data_o,
  output logic data_oe_o
);
  localparam int SPACE_CYC = 3000; // 12 us of clocks
  localparam int CYC_US = 250; // clocks per microsecond
  logic la_last = 1'b0; // last command written was a load address
  // wait owed after a command, counted from ready high, in clocks
  function automatic int wait_cyc(input logic [7:0] c, input logic la);
    case (c[6:4])
      OP_READ_BRANCH: wait_cyc = BUSY_RB_US * CYC_US;
      OP_LOAD_ADDR: wait_cyc = BUSY_LA_US * CYC_US;
      OP_SPEAK: wait_cyc = (la ? BUSY_SPK_LA_US : BUSY_SPK_US) * CYC_US;
      OP_SPEAK_EXT: wait_cyc = BUSY_SPX_US * CYC_US;
      OP_RESET: wait_cyc = BUSY_RST_US * CYC_US;
      default: wait_cyc = 0;
    endcase
  endfunction
  initial begin
    write_select_n_o = 1'b1;
    read_select_n_o = 1'b1;
    data_o = 8'h00;
    data_oe_o = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // bounded wait so a stuck ready cannot hang the model
  task automatic wait_rdy(input logic lvl);
    int n;
    n = 0;
    while (ready_i !== lvl && n < 200_000) begin
      @(posedge mclk_i);
      n++;
    end
  endtask
  // write one byte, finish only when ready drops
  task automatic write_byte(input logic [7:0] b, input bit early);
    int n;
    int w;
    @(posedge mclk_i);
    data_o <= b;
    data_oe_o <= 1'b1;
    write_select_n_o <= 1'b0;
    wait_rdy(1'b1);
    n = 0;
    while (ready_i !== 1'b0 && n < 200_000) begin
      @(posedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    write_select_n_o <= 1'b1;
    idle(25); // data hold after strobe rise
    data_oe_o <= 1'b0;
    data_o <= ~b; // released line must not keep the old value
    idle(SPACE_CYC);
    // early skips the command wait on purpose, to land inside the busy period
    w = wait_cyc(b, la_last) - n - SPACE_CYC - 26;
    if (!early && w > 0) idle(w);
    la_last = (b[6:4] == OP_LOAD_ADDR);
  endtask
  // read one byte, strobe held well past ready rise
  task automatic read_byte(output logic [7:0] b);
    @(posedge mclk_i);
    read_select_n_o <= 1'b0;
    wait_rdy(1'b1);
    idle(2000);
    wait_rdy(1'b0);
    b = bus_i;
    @(posedge mclk_i);
    read_select_n_o <= 1'b1;
    idle(SPACE_CYC);
  endtask
  // both strobes low together asks for the power-up clear
  task automatic clear_both(input int n);
    @(posedge mclk_i);
    write_select_n_o <= 1'b0;
    read_select_n_o <= 1'b0;
    idle(n);
    write_select_n_o <= 1'b1;
    read_select_n_o <= 1'b1;
    idle(SPACE_CYC);
  endtask
endmodule

// *** tb/speech_host_port_tb.sv ***
// self-checking bench for the speech host port timing block
`timescale 1ns/1ps
module speech_host_port_tb
  import speech_port_pkg::*;
;
  logic mclk_i, resetn_i, clk_src_strap_i, oscillator_input_i;
  logic [7:0] status_i, read_data_i, h_d, bus, data_o, cmd_o, b;
  logic ws_n, rs_n, h_oe, data_oe_o, ready_o, mem_clk_tick_o, cmd_valid_o, power_clear_o;
  logic rdy_q = 1'b0, oe_q = 1'b0, rs_q = 1'b1;
  int err_total = 0, total_checks = 0, cyc = 0, rise_c = 0, fall_c = 0;
  int oe_fall_c = 0, rs_rise_c = 0, n_rise = 0, n_valid = 0, pc_seen = 0;
  int tick_c = 0, gap_c = 0, r0, v0;
  // host drives the bus when enabled, else the device, else a drifted level
  assign bus = h_oe ? h_d : (data_oe_o ? data_o : h_d);
  speech_host_port u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .write_select_n_i(ws_n),
    .read_select_n_i(rs_n), .data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
    .ready_o(ready_o), .clk_src_strap_i(clk_src_strap_i),
    .oscillator_input_i(oscillator_input_i), .mem_clk_tick_o(mem_clk_tick_o),
    .status_i(status_i), .read_data_i(read_data_i), .cmd_o(cmd_o),
    .cmd_valid_o(cmd_valid_o), .power_clear_o(power_clear_o));
  host_cpu_model u_host (.mclk_i(mclk_i), .ready_i(ready_o), .bus_i(bus),
    .write_select_n_o(ws_n), .read_select_n_o(rs_n), .data_o(h_d), .data_oe_o(h_oe));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // edge timestamps measured by the bench, never by the design
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    rdy_q <= ready_o;
    oe_q <= data_oe_o;
    rs_q <= rs_n;
    if (ready_o === 1'b1 && rdy_q === 1'b0) begin
      rise_c <= cyc;
      n_rise <= n_rise + 1;
    end
    if (ready_o === 1'b0 && rdy_q === 1'b1) fall_c <= cyc;
    if (data_oe_o === 1'b0 && oe_q === 1'b1) oe_fall_c <= cyc;
    if (rs_n === 1'b1 && rs_q === 1'b0) rs_rise_c <= cyc;
    if (cmd_valid_o === 1'b1) n_valid <= n_valid + 1;
    if (power_clear_o === 1'b1) pc_seen <= 1;
    if (mem_clk_tick_o === 1'b1) begin
      tick_c <= cyc;
      gap_c <= cyc - tick_c;
    end
  end
  // near-320 kHz square wave, 395 clocks per half period: detuned by about one
  // percent so that the source switch shows in the memory tick spacing
  initial begin
    oscillator_input_i = 1'b0;
    forever begin
      repeat (395) @(posedge mclk_i);
      oscillator_input_i <= ~oscillator_input_i;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic in_rng(input int v, input int lo, input int hi);
    chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask
  task automatic t_clear();
    r0 = n_rise;
    v0 = n_valid;
    u_host.clear_both(50);
    chk(pc_seen, 1);
    chk(n_rise - r0, 0);
    chk(n_valid - v0, 0);
    chk(power_clear_o, 1'b0);
  endtask
  // read-byte command, then the fetched byte
  task automatic t_read_byte();
    v0 = n_valid;
    u_host.write_byte(8'h10, 1'b0);
    in_rng(fall_c - rise_c, 4500, 6500);
    chk(cmd_o, 8'h10);
    chk(n_valid - v0, 1);
    r0 = fall_c;
    u_host.read_byte(b);
    in_rng(fall_c - r0, 1, 80_000);
    chk(b, 8'h3C);
  endtask
  task automatic t_status();
    status_i <= 8'h5A;
    read_data_i <= 8'hE7;
    u_host.read_byte(b);
    in_rng(fall_c - rise_c, 1500, 2750);
    chk(b, 8'h5A);
    in_rng(oe_fall_c - rs_rise_c, 1, 2625);
  endtask
  // second command lands inside the first one's busy period
  task automatic t_busy();
    u_host.write_byte(8'h40, 1'b1);
    r0 = rise_c;
    u_host.write_byte(8'h41, 1'b0);
    in_rng(fall_c - r0, BUSY_LA_US * 250, 200_000);
    chk(cmd_o, 8'h41);
  endtask
  task automatic t_clock();
    u_host.idle(4000);
    in_rng(gap_c, 1562, 1563);
    clk_src_strap_i <= 1'b0;
    u_host.idle(8000);
    in_rng(gap_c, 1580, 1580);
    clk_src_strap_i <= 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    resetn_i = 1'b0;
    clk_src_strap_i = 1'b1;
    status_i = 8'hA5;
    read_data_i = 8'h3C;
    repeat (6) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_clear();
    t_read_byte();
    t_status();
    t_busy();
    t_clock();
    report_and_stop();
  end
  // watchdog sized well beyond the whole sequence
  initial begin
    #800_000;
    err_total++;
    report_and_stop();
  end
endmodule
